// file: logic/mpt_match_unit.sv
// One match channel: shadow value, active value and equality match.
// Assumes the count and the advance tick come from the timer core.
`timescale 1ns/10ps
module mpt_match_unit import mpt_pkg::*; (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // Software side
  input  wire logic              wr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              direct_in,
  input  wire logic              load_in,
  // Timer side
  input  wire logic [DATA_W-1:0] count_in,
  input  wire logic              adv_in,
  output logic                   match_out,
  output logic [DATA_W-1:0]      shadow_out
);

  logic [DATA_W-1:0] shadow_r;
  logic [DATA_W-1:0] active_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shadow_r <= ZERO_W;
    end else if (wr_in) begin
      shadow_r <= wdata_in;
    end
  end

  // Active value moves only on a release or in plain timer use
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      active_r <= ZERO_W;
    end else if (wr_in && direct_in) begin
      active_r <= wdata_in;
    end else if (load_in) begin
      active_r <= shadow_r;
    end
  end

  assign match_out  = adv_in && (count_in == active_r);
  assign shadow_out = shadow_r;

endmodule : mpt_match_unit

// file: logic/mpt_pkg.sv
// Package for the match based pulse width timer: register map,
// field positions, reset values and the register port carrier.
// Assumes a 32-bit register port with byte addresses.
package mpt_pkg;

  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int N_MATCH = 7;
  localparam int N_OUT   = 6;
  localparam int N_CAP   = 2;
  localparam int MCTL_W  = 3 * N_MATCH;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_COUNT  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PLIM   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PCNT   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_MCTL   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_MATCH0 = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_REL    = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_OCTL   = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_SRC    = 8'h3C;
  localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h40;
  localparam logic [ADDR_W-1:0] MATCH_STEP = 8'h04;

  // Control register bits
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CLR = 1;
  localparam int CTRL_MOD = 3;

  // Match control: three bits per match
  localparam int MC_INT  = 0;
  localparam int MC_RST  = 1;
  localparam int MC_STP  = 2;

  // Output control: double edge select at bit n, enable at bit n+8
  localparam int OC_EN_BASE = 8;

  // Count source: mode in bits 1:0, capture input select at bit 2
  localparam int SRC_SEL = 2;
  localparam logic [1:0] SRC_TIMER = 2'h0;
  localparam logic [1:0] SRC_RISE  = 2'h1;
  localparam logic [1:0] SRC_FALL  = 2'h2;
  localparam logic [1:0] SRC_BOTH  = 2'h3;

  localparam logic [DATA_W-1:0] ZERO_W = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ONE_W  = 32'h0000_0001;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } mpt_bus_req_t;

endpackage : mpt_pkg

// file: logic/mpt_pwm_timer.sv
// Match based pulse width timer: 32-bit count, 32-bit prescaler,
// seven match channels, six modulated outputs and one interrupt.
// Assumes a synchronous register port and synchronous count inputs.
//
// Notes on behaviour
// - Period match restarts the count; every output shares that cycle.
// - Single edge output rises at period match, falls at its own match.
// - A single edge output held constant low gets no start-of-cycle rise.
// - Double edge output rises on one match, falls on the next one.
// - Seven match channels drive six single or three double edge outputs.
// - One match per single edge output, two per double edge output.
// - Each match may keep counting, stop or reset, each with interrupt.
// - New match values take effect at cycle start after software release.
// - Period and width are any count; one repetition rate for all.
// - Count clock cycles, or edges on one selected capture input.
// - Without modulation it is a plain 32-bit timer with prescaler.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module mpt_pwm_timer import mpt_pkg::*; (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  // Register port
  input  wire mpt_bus_req_t  bus_in,
  output logic [DATA_W-1:0]  rdata_out,
  // Count source inputs
  input  wire logic [N_CAP-1:0] cap_in,
  // Modulated outputs and interrupt
  output logic [N_OUT:1]     pwm_out,
  output logic               irq_out
);

  // Control state
  logic                 run_r;
  logic                 clr_r;
  logic                 mod_r;
  logic [DATA_W-1:0]    count_r;
  logic [DATA_W-1:0]    plim_r;
  logic [DATA_W-1:0]    pcnt_r;
  logic [MCTL_W-1:0]    mctl_r;
  logic [N_MATCH-1:0]   rel_r;
  logic [N_OUT:1]       dbl_r;
  logic [N_OUT:1]       oen_r;
  logic [1:0]           src_r;
  logic                 sel_r;
  logic [N_CAP-1:0]     cap_prev_r;
  logic [N_MATCH-1:0]   stat_r;
  logic [N_MATCH-1:0]   mask_r;
  logic [N_OUT:1]       pwm_r;
  logic                 irq_r;
  logic [DATA_W-1:0]    rdata_r;

  // Derived signals
  logic                 wr_ctrl;
  logic                 wr_count;
  logic                 wr_plim;
  logic                 wr_pcnt;
  logic                 wr_mctl;
  logic                 wr_rel;
  logic                 wr_octl;
  logic                 wr_src;
  logic                 wr_stat;
  logic                 wr_mask;
  logic [N_MATCH-1:0]   wr_match;
  logic [N_MATCH-1:0]   match;
  logic [N_MATCH-1:0]   load;
  logic [N_MATCH-1:0]   m_int;
  logic [N_MATCH-1:0]   m_rst;
  logic [N_MATCH-1:0]   m_stp;
  logic [DATA_W-1:0]    shadow [N_MATCH];
  logic                 cap_now;
  logic                 cap_old;
  logic                 tick;
  logic                 adv;
  logic                 ev_reset;
  logic                 ev_stop;
  logic                 cyc_start;
  logic [N_MATCH-1:0]   stat_nxt;
  logic [DATA_W-1:0]    rdata_nxt;

  // Write decode
  assign wr_ctrl  = bus_in.wr && (bus_in.addr == OFF_CTRL);
  assign wr_count = bus_in.wr && (bus_in.addr == OFF_COUNT);
  assign wr_plim  = bus_in.wr && (bus_in.addr == OFF_PLIM);
  assign wr_pcnt  = bus_in.wr && (bus_in.addr == OFF_PCNT);
  assign wr_mctl  = bus_in.wr && (bus_in.addr == OFF_MCTL);
  assign wr_rel   = bus_in.wr && (bus_in.addr == OFF_REL);
  assign wr_octl  = bus_in.wr && (bus_in.addr == OFF_OCTL);
  assign wr_src   = bus_in.wr && (bus_in.addr == OFF_SRC);
  assign wr_stat  = bus_in.wr && (bus_in.addr == OFF_STATUS);
  assign wr_mask  = bus_in.wr && (bus_in.addr == OFF_MASK);

  // Count source selection and edge detection
  assign cap_now = cap_in[sel_r];
  assign cap_old = cap_prev_r[sel_r];

  always_comb begin
    case (src_r)
      SRC_TIMER: tick = 1'b1;
      SRC_RISE:  tick = cap_now && !cap_old;
      SRC_FALL:  tick = !cap_now && cap_old;
      SRC_BOTH:  tick = cap_now != cap_old;
      default:   tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cap_prev_r <= '0;
    end else begin
      cap_prev_r <= cap_in;
    end
  end

  // Count advances when the prescaler reaches its limit
  assign adv = run_r && !clr_r && tick && (pcnt_r == plim_r);

  // Match channels and their per-match actions
  genvar k;
  generate
    for (k = 0; k < N_MATCH; k++) begin : g_match
      assign wr_match[k] = bus_in.wr &&
        (bus_in.addr == OFF_MATCH0 + MATCH_STEP * ADDR_W'(k));
      assign m_int[k] = mctl_r[3*k + MC_INT];
      assign m_rst[k] = mctl_r[3*k + MC_RST];
      assign m_stp[k] = mctl_r[3*k + MC_STP];
      assign load[k]  = cyc_start && rel_r[k];

      mpt_match_unit u_match (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .wr_in      (wr_match[k]),
        .wdata_in   (bus_in.wdata),
        .direct_in  (!mod_r),
        .load_in    (load[k]),
        .count_in   (count_r),
        .adv_in     (adv),
        .match_out  (match[k]),
        .shadow_out (shadow[k])
      );
    end
  endgenerate

  // Period match forces the restart while modulating
  assign cyc_start = mod_r && match[0];
  assign ev_reset  = |(match & m_rst) || cyc_start;
  assign ev_stop   = |(match & m_stp);

  // Timer control register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      run_r <= 1'b0;
      clr_r <= 1'b0;
      mod_r <= 1'b0;
    end else if (wr_ctrl) begin
      run_r <= bus_in.wdata[CTRL_RUN];
      clr_r <= bus_in.wdata[CTRL_CLR];
      mod_r <= bus_in.wdata[CTRL_MOD];
    end else if (ev_stop) begin
      run_r <= 1'b0;
    end
  end

  // Main 32-bit count
  always_ff @(posedge clk_in) begin
    if (rst_in || clr_r) begin
      count_r <= ZERO_W;
    end else if (wr_count) begin
      count_r <= bus_in.wdata;
    end else if (adv) begin
      if (ev_reset) begin
        count_r <= ZERO_W;
      end else begin
        count_r <= count_r + ONE_W;
      end
    end
  end

  // Prescale counter
  always_ff @(posedge clk_in) begin
    if (rst_in || clr_r) begin
      pcnt_r <= ZERO_W;
    end else if (wr_pcnt) begin
      pcnt_r <= bus_in.wdata;
    end else if (run_r && tick) begin
      if (pcnt_r == plim_r) begin
        pcnt_r <= ZERO_W;
      end else begin
        pcnt_r <= pcnt_r + ONE_W;
      end
    end
  end

  // Prescale limit, match control, output control, count source
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      plim_r <= ZERO_W;
    end else if (wr_plim) begin
      plim_r <= bus_in.wdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mctl_r <= '0;
    end else if (wr_mctl) begin
      mctl_r <= bus_in.wdata[MCTL_W-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dbl_r <= '0;
      oen_r <= '0;
    end else if (wr_octl) begin
      dbl_r <= bus_in.wdata[N_OUT:1];
      oen_r <= bus_in.wdata[OC_EN_BASE+N_OUT:OC_EN_BASE+1];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      src_r <= SRC_TIMER;
      sel_r <= 1'b0;
    end else if (wr_src) begin
      src_r <= bus_in.wdata[1:0];
      sel_r <= bus_in.wdata[SRC_SEL];
    end
  end

  // Release bits: software sets, cycle start consumes
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rel_r <= '0;
    end else begin
      rel_r <= (rel_r & ~load) |
               (wr_rel ? bus_in.wdata[N_MATCH-1:0] : '0);
    end
  end

  // Modulated outputs
  genvar n;
  generate
    for (n = 1; n <= N_OUT; n++) begin : g_out
      logic set_s;
      logic clr_s;
      if (n == 1) begin : g_single
        assign set_s = match[0];
      end else begin : g_mixed
        assign set_s = dbl_r[n] ? match[n-1] : match[0];
      end
      assign clr_s = match[n];

      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          pwm_r[n] <= 1'b0;
        end else if (!mod_r || !oen_r[n]) begin
          pwm_r[n] <= 1'b0;
        end else if (clr_s) begin
          pwm_r[n] <= 1'b0;
        end else if (set_s) begin
          pwm_r[n] <= 1'b1;
        end
      end
    end
  endgenerate

  // Interrupt status: set wins over a write-one clear
  assign stat_nxt = (stat_r & ~(wr_stat ? bus_in.wdata[N_MATCH-1:0] : '0))
                    | (match & m_int);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mask_r <= '0;
    end else if (wr_mask) begin
      mask_r <= bus_in.wdata[N_MATCH-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_nxt & (wr_mask ? bus_in.wdata[N_MATCH-1:0] : mask_r));
    end
  end

  // Read mux
  always_comb begin
    rdata_nxt = ZERO_W;
    case (bus_in.addr)
      OFF_STATUS: rdata_nxt[N_MATCH-1:0] = stat_r;
      OFF_CTRL: begin
        rdata_nxt[CTRL_RUN] = run_r;
        rdata_nxt[CTRL_CLR] = clr_r;
        rdata_nxt[CTRL_MOD] = mod_r;
      end
      OFF_COUNT:  rdata_nxt = count_r;
      OFF_PLIM:   rdata_nxt = plim_r;
      OFF_PCNT:   rdata_nxt = pcnt_r;
      OFF_MCTL:   rdata_nxt[MCTL_W-1:0] = mctl_r;
      OFF_REL:    rdata_nxt[N_MATCH-1:0] = rel_r;
      OFF_OCTL: begin
        rdata_nxt[N_OUT:1] = dbl_r;
        rdata_nxt[OC_EN_BASE+N_OUT:OC_EN_BASE+1] = oen_r;
      end
      OFF_SRC: begin
        rdata_nxt[1:0]     = src_r;
        rdata_nxt[SRC_SEL] = sel_r;
      end
      OFF_MASK:   rdata_nxt[N_MATCH-1:0] = mask_r;
      default: begin
        for (int i = 0; i < N_MATCH; i++) begin
          if (bus_in.addr == OFF_MATCH0 + MATCH_STEP * ADDR_W'(i)) begin
            rdata_nxt = shadow[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_r <= ZERO_W;
    end else if (bus_in.rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= ZERO_W;
    end
  end

  assign rdata_out = rdata_r;
  assign pwm_out   = pwm_r;
  assign irq_out   = irq_r;

endmodule : mpt_pwm_timer

// file: tb/mpt_load_model.sv
// Load model on the modulated outputs: records which outputs rose.
// Assumes output levels are sampled on the timer clock.
`timescale 1ns/10ps
module mpt_load_model import mpt_pkg::*; (
  // Clock and reset
  input  wire logic           clk_in,
  input  wire logic           rst_in,
  // Driven loads
  input  wire logic [N_OUT:1] pwm_in,
  output logic [N_OUT:1]      seen_out
);
  logic [N_OUT:1] last_r;
  always_ff @(posedge clk_in) begin
    last_r   <= rst_in ? '0 : pwm_in;
    seen_out <= rst_in ? '0 : seen_out | (pwm_in & ~last_r);
  end
endmodule : mpt_load_model

// file: tb/mpt_pwm_timer_chk.sv
// Checker on the timer's ports: register port and output relations.
// Assumes a bind to mpt_pwm_timer from the testbench top file.
`timescale 1ns/10ps
module mpt_pwm_timer_chk import mpt_pkg::*; (
  // Clock and reset
  input wire logic              clk_in,
  input wire logic              rst_in,
  // Watched ports
  input wire mpt_bus_req_t      bus_in,
  input wire logic [DATA_W-1:0] rdata_out,
  input wire logic [N_CAP-1:0]  cap_in,
  input wire logic [N_OUT:1]    pwm_out,
  input wire logic              irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_mctl_back;
    bus_in.wr && bus_in.addr == OFF_MCTL ##1
    bus_in.rd && bus_in.addr == OFF_MCTL;
  endsequence
  a_reset_quiet: assert property (
    $fell(rst_in) |-> pwm_out == 6'h00 && !irq_out && rdata_out == ZERO_W)
    else $error("outputs busy after reset");
  a_rdata_idle: assert property (
    !$past(bus_in.rd) |-> rdata_out == ZERO_W)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (
    bus_in.rd && bus_in.addr == 8'h44 |=> rdata_out == ZERO_W)
    else $error("unmapped read not zero");
  a_mctl_back: assert property (
    s_mctl_back |=> rdata_out == ($past(bus_in.wdata, 2) & 32'h001F_FFFF))
    else $error("match control read back wrong");
  a_mod_off_low: assert property (
    bus_in.wr && bus_in.addr == OFF_CTRL && !bus_in.wdata[CTRL_MOD]
    |-> ##2 pwm_out == 6'h00)
    else $error("output high without modulation");
  a_enable_gates: assert property (
    bus_in.wr && bus_in.addr == OFF_OCTL
    |-> ##2 (pwm_out & ~$past(bus_in.wdata[14:9], 2)) == 6'h00)
    else $error("disabled output high");
  a_halt_holds: assert property (
    bus_in.wr && bus_in.addr == OFF_CTRL && !bus_in.wdata[CTRL_RUN]
    && bus_in.wdata[CTRL_MOD] |-> ##2 $stable(pwm_out)[*4])
    else $error("outputs move while stopped");
  a_mask_quiets: assert property (
    bus_in.wr && bus_in.addr == OFF_MASK && bus_in.wdata[6:0] == 7'h00
    |-> ##2 !irq_out[*3])
    else $error("interrupt while all masked");
endmodule : mpt_pwm_timer_chk

// file: tb/tb_top.sv
// Testbench: register tasks, integer model of count, matches, status
// and outputs, random capture inputs, load model on the outputs.
// Assumes a 50 ns clock and a synchronous active high reset.
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: %h want %h", $time, a, b); end end
module tb_top import mpt_pkg::*; ;
  typedef struct {
    int unsigned cnt, pc, lim, ctl, mc, rel, oc, src, msk, st, pw, ex;
    int unsigned cp, q, seen, act[N_MATCH], sh[N_MATCH];
  } mpt_model_t;
  logic              clk_in = 1'b0;
  logic              rst_in = 1'b1;
  mpt_bus_req_t      bus_in = '0;
  logic [N_CAP-1:0]  cap_in = '0;
  logic [DATA_W-1:0] rdata_out;
  logic [N_OUT:1]    pwm_out;
  logic [N_OUT:1]    seen;
  logic              irq_out;
  int                err_count = 0;
  int                compares = 0;
  int unsigned       rng = 82;
  mpt_model_t        m;

  mpt_pwm_timer dut_u (.clk_in(clk_in), .rst_in(rst_in), .bus_in(bus_in),
    .rdata_out(rdata_out), .cap_in(cap_in), .pwm_out(pwm_out),
    .irq_out(irq_out));
  mpt_load_model load_u (.clk_in(clk_in), .rst_in(rst_in),
    .pwm_in(pwm_out), .seen_out(seen));

  always #25 clk_in = ~clk_in;

  function int unsigned rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd

  always @(posedge clk_in) cap_in <= 2'(rnd());

  task automatic give_verdict();
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    bus_in <= '{a, d, 1'b1, 1'b0};
  endtask : wr

  task automatic gap(input int n);
    @(posedge clk_in);
    bus_in <= '0;
    repeat (n) @(posedge clk_in);
  endtask : gap

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk_in);
    bus_in <= '{a, ZERO_W, 1'b0, 1'b1};
    @(posedge clk_in);
    bus_in <= '0;
    @(negedge clk_in);
    `CHK(rdata_out, e)
  endtask : rdc

  task automatic do_reset();
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
  endtask : do_reset

  // Reference model, updated at each edge from pre-edge inputs
  always @(posedge clk_in) begin : model_b
    bit c, pr, tk, adv, rs, sp, cl;
    bit [6:0] ev;
    int mi;
    int unsigned nx;
    mi = (int'(bus_in.addr) - int'(OFF_MATCH0)) / 4;
    if (rst_in) m = '{default: 0};
    else begin
      c = m.src[2] ? cap_in[1] : cap_in[0];
      pr = m.src[2] ? m.cp[1] : m.cp[0];
      tk = m.src[1:0] == 0 || (m.src[0] && c && !pr) || (m.src[1] && !c && pr);
      cl = m.ctl[1];
      adv = m.ctl[0] && !cl && tk && m.pc == m.lim;
      if (m.ctl[0] && tk) m.pc = adv ? 0 : m.pc + 1;
      if (bus_in.wr && bus_in.addr == OFF_STATUS) m.st &= ~bus_in.wdata;
      if (adv) begin
        rs = 0;
        sp = 0;
        for (int k = 0; k < N_MATCH; k++) begin
          ev[k] = m.cnt == m.act[k];
          rs |= ev[k] && (m.mc[3*k+1] || (k == 0 && m.ctl[3]));
          sp |= ev[k] && m.mc[3*k+2];
          if (ev[k] && m.mc[3*k]) m.st[k] = 1;
        end
        for (int n = 1; n <= N_OUT; n++) begin
          if (ev[n]) m.pw[n] = 0;
          else if (n > 1 && m.oc[n] ? ev[n-1] : ev[0]) m.pw[n] = 1;
        end
        m.cnt = rs ? 0 : m.cnt + 1;
        if (sp) m.ctl[0] = 0;
        if (ev[0] && m.ctl[3]) begin
          for (int k = 0; k < N_MATCH; k++) if (m.rel[k]) m.act[k] = m.sh[k];
          m.rel = 0;
        end
      end
      if (bus_in.wr) case (bus_in.addr)
        OFF_CTRL: m.ctl = bus_in.wdata;
        OFF_COUNT: m.cnt = bus_in.wdata;
        OFF_PLIM: m.lim = bus_in.wdata;
        OFF_PCNT: m.pc = bus_in.wdata;
        OFF_MCTL: m.mc = bus_in.wdata;
        OFF_REL: m.rel |= bus_in.wdata;
        OFF_OCTL: m.oc = bus_in.wdata;
        OFF_SRC: m.src = bus_in.wdata;
        OFF_MASK: m.msk = bus_in.wdata;
        default: if (mi >= 0 && mi < N_MATCH) begin
          m.sh[mi] = bus_in.wdata;
          if (!m.ctl[3]) m.act[mi] = bus_in.wdata;
        end
      endcase
      if (cl) begin
        m.cnt = 0;
        m.pc = 0;
      end
      m.q = bus_in.wr ? 0 : m.q + 1;
      m.cp = cap_in;
      nx = m.ctl[3] ? m.pw & (m.oc >> 8) & 32'h7E : 0;
      m.seen |= nx & ~m.ex;
      m.ex = nx;
    end
  end

  always @(negedge clk_in) if (!rst_in && m.q > 1) begin
    `CHK(pwm_out, m.ex[6:1])
    `CHK(irq_out, |(m.st & m.msk))
  end

  initial begin : main_b
    int unsigned p;
    int unsigned mv[N_MATCH];
    do_reset();
    rdc(OFF_CTRL, ZERO_W);
    rdc(8'h44, ZERO_W);
    // Prescaled timer with interrupt, then stop and reset on match
    wr(OFF_PLIM, 32'h0000_0002);
    wr(OFF_MATCH0 + 8'h04, 32'h0000_0005);
    wr(OFF_MATCH0 + 8'h08, 32'h0000_0009);
    wr(OFF_MASK, 32'h0000_0006);
    wr(OFF_MCTL, 32'h0000_01C8);
    rdc(OFF_MCTL, 32'h0000_01C8);
    wr(OFF_CTRL, ONE_W);
    gap(40);
    rdc(OFF_COUNT, ZERO_W);
    rdc(OFF_CTRL, ZERO_W);
    rdc(OFF_STATUS, 32'h0000_0006);
    wr(OFF_STATUS, 32'h0000_0002);
    rdc(OFF_STATUS, 32'h0000_0004);
    wr(OFF_MASK, ZERO_W);
    wr(OFF_MCTL, ZERO_W);
    wr(OFF_PLIM, ZERO_W);
    wr(OFF_PCNT, ZERO_W);
    // Every count source and capture select
    for (int s = 1; s < 8; s++) begin
      wr(OFF_SRC, 32'(s));
      wr(OFF_COUNT, ZERO_W);
      wr(OFF_CTRL, ONE_W);
      gap(30);
      wr(OFF_CTRL, ZERO_W);
      gap(2);
      rdc(OFF_COUNT, m.cnt);
    end
    // Hold-clear keeps count and prescaler at zero while running
    wr(OFF_PLIM, 32'h0000_0003);
    wr(OFF_CTRL, 32'h0000_0003);
    gap(3);
    rdc(OFF_COUNT, ZERO_W);
    rdc(OFF_PCNT, ZERO_W);
    rdc(OFF_CTRL, 32'h0000_0003);
    // Modulation: single, double, constant low, then shadow release
    do_reset();
    p = 10 + rnd() % 6;
    mv = '{p, 2, 5, p, 6, 3, rnd() % p};
    foreach (mv[k]) wr(OFF_MATCH0 + 8'(4 * k), mv[k]);
    wr(OFF_OCTL, 32'h0000_7E26);
    wr(OFF_CTRL, 32'h0000_0009);
    gap(60);
    wr(OFF_MATCH0 + 8'h04, 32'h0000_0004);
    gap(30);
    rdc(OFF_MATCH0 + 8'h04, 32'h0000_0004);
    wr(OFF_MATCH0, p + 3);
    wr(OFF_REL, 32'h0000_0003);
    gap(50);
    rdc(OFF_REL, ZERO_W);
    wr(OFF_OCTL, 32'h0000_0E26);
    gap(40);
    wr(OFF_CTRL, 32'h0000_0008);
    gap(8);
    wr(OFF_CTRL, ZERO_W);
    gap(4);
    `CHK(seen, m.seen[6:1])
    give_verdict();
  end

  initial begin : watchdog_b
    repeat (5000) @(posedge clk_in);
    err_count++;
    give_verdict();
  end
endmodule : tb_top

bind mpt_pwm_timer mpt_pwm_timer_chk chk_u (.clk_in(clk_in),
  .rst_in(rst_in), .bus_in(bus_in), .rdata_out(rdata_out),
  .cap_in(cap_in), .pwm_out(pwm_out), .irq_out(irq_out));
